// file: nsx_consts.svh
// Purpose: constants for the nibble swap / xor / direction load datapath
// Assumes: included by its bare name
// Notes: widths, direction port selects and reset values
`ifndef NSX_CONSTS_SVH
`define NSX_CONSTS_SVH
`define NSX_DATA_W 8
`define NSX_ADDR_W 7
`define NSX_ADDR_MAX 7'h7f
`define NSX_DIR_A_SEL 7'h05
`define NSX_DIR_B_SEL 7'h06
`define NSX_DIR_C_SEL 7'h07
`define NSX_ACC_RST 8'h00
`define NSX_DIR_RST 8'hff
`define NSX_ZERO_RST 1'b0
`define NSX_WE_RST 1'b0
`define NSX_WADDR_RST 7'h00
`define NSX_WDATA_RST 8'h00
`define NSX_LO_MSB 3
`define NSX_HI_LSB 4
`endif

// file: nsx_pkg.sv
// Purpose: types for the nibble swap / xor / direction load datapath
// Assumes: nothing
// Notes: operation encoding shared by the core and its result unit
`default_nettype none
package nsx_pkg;
	typedef enum logic [2:0] {
		NSX_OP_IDLE = 3'b000,
		NSX_OP_NIBBLE_EXCHANGE = 3'b001,
		NSX_OP_LITERAL_XOR = 3'b010,
		NSX_OP_REGISTER_XOR = 3'b011,
		NSX_OP_DIRECTION_LOAD = 3'b100
	} nsx_op_t;
endpackage
`default_nettype wire

// file: nsx_result.sv
// Purpose: combinational result of one operation
// Assumes: operands already valid in the same cycle
// Notes: no state; the core registers everything
`timescale 1ns/1ns
`default_nettype none
`include "nsx_consts.svh"
module nsx_result (
	input wire nsx_pkg::nsx_op_t op_i,
	input wire logic [7:0] acc_i,
	input wire logic [7:0] reg_i,
	input wire logic [7:0] lit_i,
	output logic [7:0] res_o,
	output logic zero_o
);
	import nsx_pkg::*;
	always_comb begin
		unique case (op_i)
			NSX_OP_NIBBLE_EXCHANGE: begin
				// low nibble goes up, high nibble comes down
				res_o = {reg_i[`NSX_LO_MSB:0], reg_i[7:`NSX_HI_LSB]}; // RQ1
			end
			NSX_OP_LITERAL_XOR: begin
				res_o = acc_i ^ lit_i; // RQ3
			end
			NSX_OP_REGISTER_XOR: begin
				res_o = acc_i ^ reg_i; // RQ4
			end
			NSX_OP_DIRECTION_LOAD: begin
				res_o = acc_i; // RQ6
			end
			default: begin
				res_o = acc_i;
			end
		endcase
		zero_o = (res_o == 8'h00); // RQ7
	end
endmodule
`default_nettype wire

// file: nsx_exec.sv
// Purpose: execution datapath for swap, xor and direction load operations
// Assumes: decoder gives one op per cycle with valid operands in that cycle
// Notes: register write-back leaves as a one-cycle strobe to the file
`timescale 1ns/1ns
`default_nettype none
`include "nsx_consts.svh"
// How it works
// RQ1: swap exchanges the two nibbles of register
// RQ2: swap result to accumulator or register, no flags
// RQ3: literal xor into accumulator, zero flag only
// RQ4: register xor with accumulator, zero flag only
// RQ5: register xor result to accumulator or register
// RQ6: direction load copies accumulator to port 5/6/7
// RQ7: zero flag set exactly when an xor result is zero
module nsx_exec (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic op_valid_i,
	input wire nsx_pkg::nsx_op_t op_i,
	input wire logic [6:0] addr_i,
	input wire logic dest_sel_i,
	input wire logic [7:0] literal_i,
	input wire logic [7:0] reg_rdata_i,
	output logic [7:0] acc_o,
	output logic zero_o,
	output logic reg_we_o,
	output logic [6:0] reg_waddr_o,
	output logic [7:0] reg_wdata_o,
	output logic [7:0] port_a_direction_o,
	output logic [7:0] port_b_direction_o,
	output logic [7:0] port_c_direction_o
);
	import nsx_pkg::*;

	typedef struct packed {
		logic [7:0] acc;
		logic zero;
		logic we;
		logic [6:0] waddr;
		logic [7:0] wdata;
		logic [7:0] dir_a;
		logic [7:0] dir_b;
		logic [7:0] dir_c;
	} nsx_state_t;

	nsx_state_t st_ff;
	nsx_state_t nxt_st;
	logic [7:0] res;
	logic res_zero;

	nsx_result u_result (
		.op_i(op_i),
		.acc_i(st_ff.acc),
		.reg_i(reg_rdata_i),
		.lit_i(literal_i),
		.res_o(res),
		.zero_o(res_zero)
	);

	always_comb begin
		nxt_st = st_ff;
		// write strobe lasts a single cycle
		nxt_st.we = 1'b0;
		if (op_valid_i) begin
			unique case (op_i)
				NSX_OP_NIBBLE_EXCHANGE, NSX_OP_REGISTER_XOR: begin
					if (dest_sel_i) begin
						nxt_st.we = 1'b1; // RQ2 RQ5
						nxt_st.waddr = addr_i; // RQ4
						nxt_st.wdata = res;
					end else begin
						nxt_st.acc = res; // RQ2 RQ5
					end
					if (op_i == NSX_OP_REGISTER_XOR) begin
						nxt_st.zero = res_zero; // RQ4 RQ7
					end
				end
				NSX_OP_LITERAL_XOR: begin
					nxt_st.acc = res; // RQ3
					nxt_st.zero = res_zero; // RQ3 RQ7
				end
				NSX_OP_DIRECTION_LOAD: begin
					// other operand values are ignored, nothing changes
					if (addr_i == `NSX_DIR_A_SEL) begin
						nxt_st.dir_a = res; // RQ6
					end
					if (addr_i == `NSX_DIR_B_SEL) begin
						nxt_st.dir_b = res; // RQ6
					end
					if (addr_i == `NSX_DIR_C_SEL) begin
						nxt_st.dir_c = res; // RQ6
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_ff.acc <= `NSX_ACC_RST;
			st_ff.zero <= `NSX_ZERO_RST;
			st_ff.we <= `NSX_WE_RST;
			st_ff.waddr <= `NSX_WADDR_RST;
			st_ff.wdata <= `NSX_WDATA_RST;
			// pins start as inputs, safest default
			st_ff.dir_a <= `NSX_DIR_RST;
			st_ff.dir_b <= `NSX_DIR_RST;
			st_ff.dir_c <= `NSX_DIR_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign acc_o = st_ff.acc;
	assign zero_o = st_ff.zero;
	assign reg_we_o = st_ff.we;
	assign reg_waddr_o = st_ff.waddr;
	assign reg_wdata_o = st_ff.wdata;
	assign port_a_direction_o = st_ff.dir_a;
	assign port_b_direction_o = st_ff.dir_b;
	assign port_c_direction_o = st_ff.dir_c;

	// antecedents, sampled at the edge that takes the op
	sequence s_swap_reg;
		op_valid_i && op_i == NSX_OP_NIBBLE_EXCHANGE && dest_sel_i;
	endsequence

	sequence s_swap_acc;
		op_valid_i && op_i == NSX_OP_NIBBLE_EXCHANGE && !dest_sel_i;
	endsequence

	sequence s_lit_xor;
		op_valid_i && op_i == NSX_OP_LITERAL_XOR;
	endsequence

	sequence s_xor_to_reg;
		op_valid_i && op_i == NSX_OP_REGISTER_XOR && dest_sel_i;
	endsequence

	sequence s_xor_to_acc;
		op_valid_i && op_i == NSX_OP_REGISTER_XOR && !dest_sel_i;
	endsequence

	sequence s_dir_load;
		op_valid_i && op_i == NSX_OP_DIRECTION_LOAD;
	endsequence

	// strobe may only stay up when the next op was taken as well
	sequence s_strobe_drop;
		!reg_we_o || $past(op_valid_i);
	endsequence

	a_swap_nibbles: assert property ( // RQ1
		@(posedge mclk_i) disable iff (!rst_b_i)
		s_swap_reg |=> reg_we_o && reg_wdata_o ==
		{$past(reg_rdata_i[3:0]), $past(reg_rdata_i[7:4])})
		else $error("swap result nibbles wrong");
	a_swap_keep_acc: assert property ( // RQ2
		@(posedge mclk_i) disable iff (!rst_b_i)
		s_swap_reg |=> $stable(acc_o) && reg_waddr_o == $past(addr_i))
		else $error("swap to register moved accumulator or address");
	a_swap_noflag: assert property ( // RQ2
		@(posedge mclk_i) disable iff (!rst_b_i)
		op_valid_i && op_i == NSX_OP_NIBBLE_EXCHANGE
		|=> $stable(zero_o))
		else $error("swap changed zero flag");
	a_swap_to_acc: assert property ( // RQ2
		@(posedge mclk_i) disable iff (!rst_b_i)
		s_swap_acc |=> !reg_we_o && acc_o ==
		{$past(reg_rdata_i[3:0]), $past(reg_rdata_i[7:4])})
		else $error("swap to accumulator wrong");
	a_lit_xor: assert property ( // RQ3
		@(posedge mclk_i) disable iff (!rst_b_i)
		s_lit_xor |=> acc_o == ($past(acc_o) ^ $past(literal_i))
		&& !reg_we_o)
		else $error("literal xor wrong");
	a_reg_xor_wb: assert property ( // RQ4
		@(posedge mclk_i) disable iff (!rst_b_i)
		s_xor_to_reg |=> (reg_we_o && reg_waddr_o == $past(addr_i)
		&& reg_wdata_o == ($past(acc_o) ^ $past(reg_rdata_i))
		&& $stable(acc_o)) ##1 s_strobe_drop)
		else $error("register xor write-back wrong");
	a_reg_xor_acc: assert property ( // RQ5
		@(posedge mclk_i) disable iff (!rst_b_i)
		s_xor_to_acc |=> acc_o == ($past(acc_o) ^ $past(reg_rdata_i))
		&& !reg_we_o)
		else $error("register xor to accumulator wrong");
	a_wb_source: assert property ( // RQ5
		@(posedge mclk_i) disable iff (!rst_b_i)
		reg_we_o |-> $past(op_valid_i) && $past(dest_sel_i))
		else $error("write strobe without a register destination");
	a_dir_port_a: assert property ( // RQ6
		@(posedge mclk_i) disable iff (!rst_b_i)
		op_valid_i && op_i == NSX_OP_DIRECTION_LOAD
		&& addr_i == `NSX_DIR_A_SEL
		|=> port_a_direction_o == $past(acc_o)
		&& $stable(port_b_direction_o)
		&& $stable(port_c_direction_o))
		else $error("direction load of port a wrong");
	a_dir_load: assert property ( // RQ6
		@(posedge mclk_i) disable iff (!rst_b_i)
		op_valid_i && op_i == NSX_OP_DIRECTION_LOAD
		&& addr_i == `NSX_DIR_B_SEL
		|=> port_b_direction_o == $past(acc_o) && $stable(zero_o)
		&& $stable(port_a_direction_o)
		&& $stable(port_c_direction_o))
		else $error("direction load wrong");
	a_dir_port_c: assert property ( // RQ6
		@(posedge mclk_i) disable iff (!rst_b_i)
		op_valid_i && op_i == NSX_OP_DIRECTION_LOAD
		&& addr_i == `NSX_DIR_C_SEL
		|=> port_c_direction_o == $past(acc_o)
		&& $stable(port_a_direction_o)
		&& $stable(port_b_direction_o))
		else $error("direction load of port c wrong");
	a_dir_refused: assert property ( // RQ6
		@(posedge mclk_i) disable iff (!rst_b_i)
		op_valid_i && op_i == NSX_OP_DIRECTION_LOAD
		&& addr_i != `NSX_DIR_A_SEL && addr_i != `NSX_DIR_B_SEL
		&& addr_i != `NSX_DIR_C_SEL
		|=> $stable(port_a_direction_o) && $stable(port_b_direction_o)
		&& $stable(port_c_direction_o))
		else $error("direction load with bad select changed a port");
	a_dir_noflag: assert property ( // RQ6
		@(posedge mclk_i) disable iff (!rst_b_i)
		s_dir_load |=> $stable(zero_o) && $stable(acc_o) && !reg_we_o)
		else $error("direction load touched accumulator or flag");
	a_ports_kept: assert property ( // RQ6
		@(posedge mclk_i) disable iff (!rst_b_i)
		op_valid_i && op_i != NSX_OP_DIRECTION_LOAD
		|=> $stable(port_a_direction_o) && $stable(port_b_direction_o)
		&& $stable(port_c_direction_o))
		else $error("port direction changed by another op");
	a_zero_flag: assert property ( // RQ7
		@(posedge mclk_i) disable iff (!rst_b_i)
		op_valid_i && (op_i == NSX_OP_LITERAL_XOR
		|| op_i == NSX_OP_REGISTER_XOR)
		|=> zero_o == (($past(acc_o)
		^ ($past(op_i) == NSX_OP_LITERAL_XOR ? $past(literal_i)
		: $past(reg_rdata_i))) == 8'h00))
		else $error("zero flag wrong");
endmodule
`default_nettype wire

// file: nsx_rf_model.sv
// Purpose: register file model facing the exec block
// Assumes: combinational read, write on the strobe edge
// Notes: idle reads show inverted data so a stale operand is seen
`timescale 1ns/1ns
`default_nettype none
module nsx_rf_model (
	input wire logic mclk_i,
	input wire logic sel_i,
	input wire logic [6:0] addr_i,
	input wire logic we_i,
	input wire logic [6:0] waddr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [128];
	initial begin
		for (int i = 0; i < 128; i++)
			mem[i] = 8'(i) ^ 8'h3c;
	end
	assign rdata_o = sel_i ? mem[addr_i] : ~mem[addr_i];
	always @(posedge mclk_i) begin
		if (we_i)
			mem[waddr_i] <= wdata_i;
	end
endmodule
`default_nettype wire

// file: nsx_exec_tb.sv
// Purpose: self-checking bench for the exec datapath
// Assumes: register file model holds addr ^ 3c at start
// Notes: rows first, then back-to-back, refusal and reset cases
`timescale 1ns/1ns
`default_nettype none
module nsx_exec_tb;
	import nsx_pkg::*;
	typedef struct packed {
		nsx_op_t op;
		logic [6:0] a;
		logic d;
		logic [7:0] k;
		logic [7:0] acc;
		logic z;
		logic we;
		logic [7:0] wd;
	} nsx_row_t;
	localparam nsx_op_t lx = NSX_OP_LITERAL_XOR;
	localparam nsx_op_t rx = NSX_OP_REGISTER_XOR;
	localparam nsx_op_t sw = NSX_OP_NIBBLE_EXCHANGE;
	localparam nsx_op_t dl = NSX_OP_DIRECTION_LOAD;
	localparam nsx_op_t id = NSX_OP_IDLE;
	logic mclk_i = 0;
	logic rst_b_i = 0;
	logic op_valid_i = 0;
	nsx_op_t op_i = NSX_OP_IDLE;
	logic [6:0] addr_i = 0;
	logic dest_sel_i = 0;
	logic [7:0] literal_i = 0;
	logic [7:0] rdata, acc_o, wdata, pa, pb, pc;
	logic [6:0] waddr;
	logic zero_o, we;
	int err_total = 0;
	int tests_run = 0;
	nsx_row_t rows [10] = '{
		'{lx, 7'h00, 1'b0, 8'ha5, 8'ha5, 1'b0, 1'b0, 8'h00},
		'{lx, 7'h00, 1'b0, 8'ha5, 8'h00, 1'b1, 1'b0, 8'h00},
		'{lx, 7'h00, 1'b0, 8'hff, 8'hff, 1'b0, 1'b0, 8'h00},
		'{rx, 7'h10, 1'b0, 8'h00, 8'hd3, 1'b0, 1'b0, 8'h00},
		'{rx, 7'h7f, 1'b1, 8'h00, 8'hd3, 1'b0, 1'b1, 8'h90},
		'{sw, 7'h7f, 1'b0, 8'h00, 8'h09, 1'b0, 1'b0, 8'h00},
		'{sw, 7'h10, 1'b1, 8'h00, 8'h09, 1'b0, 1'b1, 8'hc2},
		'{lx, 7'h00, 1'b0, 8'hcb, 8'hc2, 1'b0, 1'b0, 8'h00},
		'{rx, 7'h10, 1'b1, 8'h00, 8'hc2, 1'b1, 1'b1, 8'h00},
		'{sw, 7'h10, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00}};
	always #2 mclk_i = ~mclk_i;
	nsx_rf_model rf (.mclk_i(mclk_i), .sel_i(op_valid_i), .addr_i(addr_i),
		.we_i(we), .waddr_i(waddr), .wdata_i(wdata), .rdata_o(rdata));
	nsx_exec dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .op_valid_i(op_valid_i),
		.op_i(op_i), .addr_i(addr_i), .dest_sel_i(dest_sel_i),
		.literal_i(literal_i), .reg_rdata_i(rdata), .acc_o(acc_o),
		.zero_o(zero_o), .reg_we_o(we), .reg_waddr_o(waddr),
		.reg_wdata_o(wdata), .port_a_direction_o(pa),
		.port_b_direction_o(pb), .port_c_direction_o(pc));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task step(input nsx_op_t o, input logic [6:0] a, input logic d,
		input logic [7:0] k, input logic v);
		@(negedge mclk_i);
		op_valid_i = v;
		op_i = o;
		addr_i = a;
		dest_sel_i = d;
		literal_i = k;
	endtask
	task rst_chk();
		chk(acc_o, 8'h00);
		chk({6'h00, zero_o, we}, 8'h00);
		chk(pa & pb & pc, 8'hff);
	endtask
	task stop_test();
		$display("errors %0d, checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#40000;
		err_total++;
		stop_test();
	end
	initial begin
		repeat (8) @(negedge mclk_i);
		rst_chk();
		rst_b_i = 1;
		foreach (rows[i]) begin
			step(rows[i].op, rows[i].a, rows[i].d, rows[i].k, 1'b1);
			step(id, 7'h00, 1'b0, 8'h00, 1'b0);
			chk(acc_o, rows[i].acc);
			chk({7'h00, zero_o}, {7'h00, rows[i].z});
			chk({7'h00, we}, {7'h00, rows[i].we});
			if (rows[i].we) begin
				chk(wdata, rows[i].wd);
				chk({1'b0, waddr}, {1'b0, rows[i].a});
			end
		end
		// back to back: each load must see the accumulator just written
		step(lx, 7'h00, 1'b0, 8'h11, 1'b1);
		step(dl, 7'h05, 1'b0, 8'h00, 1'b1);
		step(lx, 7'h00, 1'b0, 8'h33, 1'b1);
		step(dl, 7'h06, 1'b0, 8'h00, 1'b1);
		step(lx, 7'h00, 1'b0, 8'h66, 1'b1);
		step(dl, 7'h07, 1'b0, 8'h00, 1'b1);
		step(dl, 7'h04, 1'b0, 8'h00, 1'b1);
		step(lx, 7'h00, 1'b0, 8'hff, 1'b0);
		step(id, 7'h00, 1'b0, 8'h00, 1'b0);
		chk(acc_o, 8'h44);
		chk({7'h00, zero_o}, 8'h00);
		chk(pa, 8'h11);
		chk(pb, 8'h22);
		chk(pc, 8'h44);
		@(negedge mclk_i);
		rst_b_i = 0;
		#1;
		rst_chk();
		// release again mid-run, op taken at the first edge after it
		repeat (2) @(negedge mclk_i);
		rst_b_i = 1;
		op_valid_i = 1'b1;
		op_i = lx;
		literal_i = 8'h5a;
		step(id, 7'h00, 1'b0, 8'h00, 1'b0);
		chk(acc_o, 8'h5a);
		chk({7'h00, zero_o}, 8'h00);
		chk(pa & pb & pc, 8'hff);
		stop_test();
	end
endmodule
`default_nettype wire
